/* File: testbench/rsd_peer_dev.sv */
`timescale 1ns/100ps
// ****************************************
// peer device sequencing outputs
// ****************************************
module rsd_peer_dev (
    input wire clk,
    input wire rst_n,
    input wire [1:0] peerUp,
    output reg [1:0] seqLine_q
);
    // moves on the falling edge so the synchroniser sees mid-cycle edges
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqLine_q <= 2'h0;
        end else begin
            seqLine_q <= peerUp;
        end
    end
endmodule // rsd_peer_dev

/* File: testbench/rsd_rail_seq_tb.sv */
`timescale 1ns/100ps
module rsd_rail_seq_tb;
    reg clk, rst_n, hwInitDone;
    reg [3:0] startReq, pgOn, pgOff, ocWarn, mFault, mRetry;
    reg [1:0] peerUp;
    reg [31:0] pinSeqCfg, slaveCfg;
    reg [3:0] pinIsInput, pinActiveHigh, onDepEn, softMode;
    reg [15:0] onRailMask, stayRailMask;
    wire [3:0] railOn, driveEn, pinOut, pinOutEn, pinIn;
    wire [47:0] pulseWidth;
    wire [1:0] peerLine;
    integer err_total, checks_done;
    // ****************************************
    // wiring
    // ****************************************
    assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & {2'h0, peerLine});
    rsd_peer_dev i_rsd_peer_dev (.clk(clk), .rst_n(rst_n),
        .peerUp(peerUp), .seqLine_q(peerLine));
    rsd_rail_seq i_rsd_rail_seq (.clk(clk), .rst_n(rst_n),
        .startReq(startReq), .pgOn(pgOn), .pgOff(pgOff), .ocWarn(ocWarn),
        .masterFault(mFault), .masterRetryDone(mRetry), .pinIn(pinIn),
        .pinIsInput(pinIsInput), .pinActiveHigh(pinActiveHigh),
        .onPinMask(16'h0001), .onRailMask(onRailMask), .onDepEn(onDepEn),
        .stayPinMask(16'h0200), .stayRailMask(stayRailMask),
        .softMode(softMode), .softDelay(64'h0000_000A_0000_0000),
        .pwStart(48'h0000_0800_0000), .pwMin(48'h0000_0500_0000),
        .slaveCfg(slaveCfg),
        .pinSeqCfg(pinSeqCfg), .hwInitDone(hwInitDone), .railOn(railOn),
        .driveEn(driveEn), .pulseWidth(pulseWidth), .pinOut(pinOut),
        .pinOutEn(pinOutEn));
    // ****************************************
    // helpers
    // ****************************************
    task step(input integer n);
        begin repeat (n) @(posedge clk); #2; end
    endtask
    task waitDrv(input integer r, input v, input integer n);
        integer i;
        begin
            i = 0;
            while (driveEn[r] !== v && i < n) begin step(1); i = i + 1; end
        end
    endtask
    task chkB(input string nm, input [3:0] e, input [3:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chkW(input string nm, input [11:0] e, input [11:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", err_total, checks_done);
            if (err_total == 0 && checks_done > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task tTurnOn;
        begin
            chkB("pinOutEn", 4'hC, pinOutEn);
            startReq[0] = 1'b1;
            step(6);
            chkB("railOn", 4'h0, railOn);
            peerUp[0] = 1'b1;
            waitDrv(0, 1'b1, 10);
            chkB("driveEn", 4'h1, driveEn);
            peerUp[0] = 1'b0;
            step(8);
            chkB("driveEn", 4'h1, driveEn);
        end
    endtask
    task tStayImm;
        begin
            startReq[1] = 1'b1;
            waitDrv(1, 1'b1, 4);
            startReq[1] = 1'b0;
            chkB("driveEn", 4'h3, driveEn);
            pgOn[2] = 1'b1; pgOff[2] = 1'b0;
            step(4);
            chkB("driveEn", 4'h3, driveEn);
            pgOn[2] = 1'b0; pgOff[2] = 1'b1;
            waitDrv(1, 1'b0, 4);
            chkB("driveEn", 4'h1, driveEn);
        end
    endtask
    task tSoft;
        begin
            peerUp[1] = 1'b1;
            step(6);
            startReq[2] = 1'b1;
            waitDrv(2, 1'b1, 4);
            startReq[2] = 1'b0;
            chkW("pulseWidth", 12'h008, pulseWidth[35:24]);
            peerUp[1] = 1'b0;
            step(12);
            chkB("driveEn", 4'h5, driveEn);
            waitDrv(2, 1'b0, 20);
            chkB("driveEn", 4'h1, driveEn);
            chkW("pulseWidth", 12'h000, pulseWidth[35:24]);
        end
    endtask
    task tSlave;
        begin
            startReq[3] = 1'b1;
            waitDrv(3, 1'b1, 4);
            startReq[3] = 1'b0;
            mFault[1] = 1'b1;
            step(6);
            chkB("driveEn", 4'h9, driveEn);
            mRetry[1] = 1'b1;
            waitDrv(3, 1'b0, 4);
            chkB("driveEn", 4'h1, driveEn);
            mFault[1] = 1'b0; mRetry[1] = 1'b0;
            startReq[3] = 1'b1;
            waitDrv(3, 1'b1, 4);
            startReq[3] = 1'b0;
            chkB("driveEn", 4'h9, driveEn);
            startReq[2] = 1'b1;
            waitDrv(2, 1'b1, 4);
            startReq[2] = 1'b0;
            mFault[0] = 1'b1;
            waitDrv(2, 1'b0, 3);
            chkB("driveEn", 4'h9, driveEn);
            mFault[0] = 1'b0;
        end
    endtask
    task tPins;
        begin
            pgOn = 4'h6; pgOff = 4'h9;
            step(2);
            chkB("pinOut", 4'h4, pinOut & 4'hC);
            pgOn[1] = 1'b0; pgOff[1] = 1'b1;
            step(1);
            chkB("pinOut", 4'h0, pinOut & 4'hC);
            ocWarn = 4'h1;
            step(1);
            chkB("pinOut", 4'h8, pinOut & 4'hC);
            pinSeqCfg[31:24] = 8'h30; hwInitDone = 1'b0;
            step(1);
            chkB("pinOut", 4'h0, pinOut & 4'hC);
            pinSeqCfg[31:24] = 8'h20; pgOn = 4'hF; pgOff = 4'h0;
            step(1);
            chkB("pinOut", 4'hC, pinOut & 4'hC);
        end
    endtask
    // ****************************************
    // run
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        err_total = 0; checks_done = 0; rst_n = 1'b0; hwInitDone = 1'b1;
        startReq = 4'h0; pgOn = 4'h0; pgOff = 4'hF; ocWarn = 4'h0;
        mFault = 4'h0; mRetry = 4'h0; peerUp = 2'h0;
        pinSeqCfg = 32'h4116_0000;
        pinIsInput = 4'h3; pinActiveHigh = 4'hF; onDepEn = 4'h1;
        softMode = 4'h4; onRailMask = 16'h0001; stayRailMask = 16'h0040;
        slaveCfg = 32'h0000_8010;
        step(2);
        rst_n = 1'b1;
        tTurnOn;
        tStayImm;
        tSoft;
        tSlave;
        tPins;
        tally_and_finish;
    end
endmodule // rsd_rail_seq_tb

/* File: testbench/rsd_seq_sva.sv */
`timescale 1ns/100ps
`include "rsd_defines.vh"
// ****************************************
// port checker
// ****************************************
module rsd_seq_sva (
    input wire clk,
    input wire rst_n,
    input wire [`RSD_RAILS-1:0] startReq,
    input wire [`RSD_RAILS-1:0] pgOn,
    input wire [`RSD_RAILS-1:0] pgOff,
    input wire [`RSD_RAILS-1:0] ocWarn,
    input wire [`RSD_PINS-1:0] pinIsInput,
    input wire [`RSD_PINS-1:0] pinActiveHigh,
    input wire [8*`RSD_PINS-1:0] pinSeqCfg,
    input wire [`RSD_PW_W*`RSD_RAILS-1:0] pwStart,
    input wire [`RSD_RAILS-1:0] railOn,
    input wire [`RSD_RAILS-1:0] driveEn,
    input wire [`RSD_PW_W*`RSD_RAILS-1:0] pulseWidth,
    input wire [`RSD_PINS-1:0] pinOut,
    input wire [`RSD_PINS-1:0] pinOutEn
);
    // shadow of the power-good latch, pgOff dominates
    reg [3:0] pgq_q;
    wire [3:0] pgq_d = (pgq_q | pgOn) & ~pgOff;
    wire [3:0] sel2 = pinSeqCfg[19:16];
    wire hi2 = !pinIsInput[2] && pinActiveHigh[2];
    wire hi3 = !pinIsInput[3] && pinActiveHigh[3];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgq_q <= 4'h0;
        end else begin
            pgq_q <= pgq_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_en; pinOutEn == ~pinIsInput; endproperty
    a_en: assert property (p_en)
        else $error("pin enable not inverse of input select");
    property p_in; (pinOut & pinIsInput) == 4'h0; endproperty
    a_in: assert property (p_in)
        else $error("input pin drives an output level");
    property p_reg;
        pinSeqCfg[23:20] == 4'h1 && hi2 |->
            pinOut[2] == (sel2 != 4'h0 && (sel2 & ~pgq_q) == 4'h0);
    endproperty
    a_reg: assert property (p_reg)
        else $error("regulating output not AND of power-good");
    property p_oc;
        pinSeqCfg[31:28] == 4'h4 && hi3 |->
            pinOut[3] == |(ocWarn & pinSeqCfg[27:24]);
    endproperty
    a_oc: assert property (p_oc)
        else $error("warning output not OR of selected rails");
    property p_pg;
        pinSeqCfg[31:28] == 4'h2 && hi3 |-> pinOut[3] == &(pgOn & ~pgOff);
    endproperty
    a_pg: assert property (p_pg)
        else $error("power good output wrong");
    property p_start;
        (railOn & ~$past(railOn) & ~$past(startReq)) == 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("rail started without a start request");
    property p_drv; (driveEn & ~railOn) == 4'h0; endproperty
    a_drv: assert property (p_drv)
        else $error("drive enabled on a rail that is off");
    property p_pws;
        $rose(railOn[2]) |-> pulseWidth[35:24] == pwStart[35:24];
    endproperty
    a_pws: assert property (p_pws)
        else $error("start pulse width wrong");
    // ramp may only step down by one while the drive stays on
    property p_ramp;
        driveEn[2] && $past(driveEn[2]) &&
            pulseWidth[35:24] != $past(pulseWidth[35:24]) |->
            pulseWidth[35:24] == $past(pulseWidth[35:24]) - 12'h001;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("soft-off ramp step wrong");
    c_on: cover property ($rose(railOn[0]));
    c_soft: cover property ($fell(driveEn[2]));
    c_pin: cover property ($rose(pinOut[2]));
endmodule // rsd_seq_sva
bind rsd_rail_seq rsd_seq_sva i_rsd_seq_sva (
    .clk(clk), .rst_n(rst_n), .startReq(startReq), .pgOn(pgOn),
    .pgOff(pgOff), .ocWarn(ocWarn), .pinIsInput(pinIsInput),
    .pinActiveHigh(pinActiveHigh), .pinSeqCfg(pinSeqCfg),
    .pwStart(pwStart), .railOn(railOn), .driveEn(driveEn),
    .pulseWidth(pulseWidth), .pinOut(pinOut), .pinOutEn(pinOutEn)
);

/* File: verilog/rsd_defines.vh */
`ifndef RSD_DEFINES_VH
`define RSD_DEFINES_VH
// ****************************************
// rail and pin counts
// ****************************************
`define RSD_RAILS 4
`define RSD_PINS 4
// ****************************************
// output dependency byte layout
// ****************************************
`define RSD_EVT_HI 7
`define RSD_EVT_LO 4
`define RSD_SEL_HI 3
`define RSD_SEL_LO 0
`define RSD_EVT_REGULATING 4'h1
`define RSD_EVT_POWER_GOOD 4'h2
`define RSD_EVT_ODRAIN_INIT 4'h3
`define RSD_EVT_OC_WARN 4'h4
// ****************************************
// fault slave choices
// ****************************************
`define RSD_SLV_NONE 2'h0
`define RSD_SLV_IMMEDIATE 2'h1
`define RSD_SLV_AFTER_RETRY 2'h2
// ****************************************
// soft-off timing
// ****************************************
`define RSD_DLY_W 16
`define RSD_PW_W 12
`define RSD_PW_STEP 12'h001
`define RSD_ZERO16 16'h0000
`define RSD_ZERO12 12'h000
`define RSD_ONE16 16'h0001
`endif

/* File: verilog/rsd_rail_ctrl.v */
`timescale 1ns/100ps
`include "rsd_defines.vh"
module rsd_rail_ctrl (
    input wire clk,
    input wire rst_n,
    input wire startReq,
    input wire startGate,
    input wire stayLoss,
    input wire slaveKill,
    input wire softMode,
    input wire [`RSD_DLY_W-1:0] softDelay,
    input wire [`RSD_PW_W-1:0] pwStart,
    input wire [`RSD_PW_W-1:0] pwMin,
    output reg railOn_q,
    output reg driveEn_q,
    output reg [`RSD_PW_W-1:0] pulseWidth_q
);
    // ****************************************
    // one-hot rail states
    // ****************************************
    localparam ST_OFF = 4'b0001;
    localparam ST_ON = 4'b0010;
    localparam ST_DLY = 4'b0100;
    localparam ST_RAMP = 4'b1000;
    reg [3:0] state_q;
    reg [`RSD_DLY_W-1:0] cnt_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
            cnt_q <= `RSD_ZERO16;
            railOn_q <= 1'b0;
            driveEn_q <= 1'b0;
            pulseWidth_q <= `RSD_ZERO12;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (startReq && startGate) begin
                        state_q <= ST_ON;
                        railOn_q <= 1'b1;
                        driveEn_q <= 1'b1;
                        pulseWidth_q <= pwStart;
                    end
                end
                ST_ON: begin
                    // stay-on loss checked first so it wins over slave
                    if (stayLoss && softMode) begin
                        state_q <= ST_DLY;
                        cnt_q <= softDelay;
                    end else if (stayLoss || slaveKill) begin
                        state_q <= ST_OFF;
                        railOn_q <= 1'b0;
                        driveEn_q <= 1'b0;
                        pulseWidth_q <= `RSD_ZERO12;
                    end
                end
                ST_DLY: begin
                    if (cnt_q == `RSD_ZERO16) begin
                        state_q <= ST_RAMP;
                    end else begin
                        cnt_q <= cnt_q - `RSD_ONE16;
                    end
                end
                ST_RAMP: begin
                    if (pulseWidth_q <= pwMin) begin
                        state_q <= ST_OFF;
                        railOn_q <= 1'b0;
                        driveEn_q <= 1'b0;
                        pulseWidth_q <= `RSD_ZERO12;
                    end else begin
                        pulseWidth_q <= pulseWidth_q - `RSD_PW_STEP;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end
endmodule // rsd_rail_ctrl

/* File: verilog/rsd_rail_seq.v */
`timescale 1ns/100ps
`include "rsd_defines.vh"
// Summary of operation
// - sequencing output active only while all selected rails are power-good
// - output drops at once when any selected rail loses power-good
// - input pin setup is separate from per-rail dependency masks
// - a rail never depends on itself; its own mask bit is ignored
// - enabled turn-on dependencies must all hold before the rail starts
// - once on, turn-on dependencies are ignored; stay-on ones govern
// - stay-on dependency acts only on active-to-inactive transition
// - with no turn-on dependencies any start request turns rail on
// - stay-on loss shuts down using the rail's own shutdown mode
// - soft-off waits delay, ramps pulse to minimum, then stops drive
// - immediate-off stops switching as soon as dependency drops
// - slave settings held per master; stay-on held per dependent rail
// - slave choice: none, immediately, or after master retries exhausted
// - fault-slave shutdown always uses immediate-off
// - stay-on dependency wins over slave relation to the same master
// - output byte: event type bits 7-4, rail mask bits 3-0
// - types: overall power-good, open-drain ready, OR of OC warnings
module rsd_rail_seq (
    clk,
    rst_n,
    startReq,
    pgOn,
    pgOff,
    ocWarn,
    masterFault,
    masterRetryDone,
    pinIn,
    pinIsInput,
    pinActiveHigh,
    onPinMask,
    onRailMask,
    onDepEn,
    stayPinMask,
    stayRailMask,
    softMode,
    softDelay,
    pwStart,
    pwMin,
    slaveCfg,
    pinSeqCfg,
    hwInitDone,
    railOn,
    driveEn,
    pulseWidth,
    pinOut,
    pinOutEn
);
    input wire clk;
    input wire rst_n;
    input wire [`RSD_RAILS-1:0] startReq;
    input wire [`RSD_RAILS-1:0] pgOn;
    input wire [`RSD_RAILS-1:0] pgOff;
    input wire [`RSD_RAILS-1:0] ocWarn;
    input wire [`RSD_RAILS-1:0] masterFault;
    input wire [`RSD_RAILS-1:0] masterRetryDone;
    input wire [`RSD_PINS-1:0] pinIn;
    input wire [`RSD_PINS-1:0] pinIsInput;
    input wire [`RSD_PINS-1:0] pinActiveHigh;
    input wire [4*`RSD_RAILS-1:0] onPinMask;
    input wire [4*`RSD_RAILS-1:0] onRailMask;
    input wire [`RSD_RAILS-1:0] onDepEn;
    input wire [4*`RSD_RAILS-1:0] stayPinMask;
    input wire [4*`RSD_RAILS-1:0] stayRailMask;
    input wire [`RSD_RAILS-1:0] softMode;
    input wire [`RSD_DLY_W*`RSD_RAILS-1:0] softDelay;
    input wire [`RSD_PW_W*`RSD_RAILS-1:0] pwStart;
    input wire [`RSD_PW_W*`RSD_RAILS-1:0] pwMin;
    input wire [8*`RSD_RAILS-1:0] slaveCfg;
    input wire [8*`RSD_PINS-1:0] pinSeqCfg;
    input wire hwInitDone;
    output wire [`RSD_RAILS-1:0] railOn;
    output wire [`RSD_RAILS-1:0] driveEn;
    output wire [`RSD_PW_W*`RSD_RAILS-1:0] pulseWidth;
    output reg [`RSD_PINS-1:0] pinOut;
    output wire [`RSD_PINS-1:0] pinOutEn;
    // ****************************************
    // input pin synchronisers
    // ****************************************
    reg [`RSD_PINS-1:0] pinMeta_q;
    reg [`RSD_PINS-1:0] pinSync_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= {`RSD_PINS{1'b0}};
            pinSync_q <= {`RSD_PINS{1'b0}};
        end else begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
        end
    end
    // pin config shared by all rails, held apart from rail masks
    wire [`RSD_PINS-1:0] pinActive;
    assign pinActive = pinIsInput & ~(pinSync_q ^ pinActiveHigh);
    // ****************************************
    // rail power-good state with hysteresis
    // ****************************************
    reg [`RSD_RAILS-1:0] pgood_q;
    reg [`RSD_RAILS-1:0] pgoodPrev_q;
    reg [`RSD_PINS-1:0] pinPrev_q;
    // sync reset level is not the idle level of an active-low pin;
    // no pin edges until both stages hold real pin values
    reg [1:0] pinWarm_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgood_q <= {`RSD_RAILS{1'b0}};
            pgoodPrev_q <= {`RSD_RAILS{1'b0}};
            pinPrev_q <= {`RSD_PINS{1'b0}};
            pinWarm_q <= 2'h0;
        end else begin
            pgood_q <= (pgood_q & ~pgOff) | (pgOn & ~pgOff);
            pgoodPrev_q <= pgood_q;
            pinWarm_q <= {pinWarm_q[0], 1'b1};
            pinPrev_q <= pinActive & {`RSD_PINS{pinWarm_q[1]}};
        end
    end
    // falling edges of sources only; never-active sources do nothing
    wire [`RSD_RAILS-1:0] railFall;
    wire [`RSD_PINS-1:0] pinFall;
    assign railFall = pgoodPrev_q & ~pgood_q;
    assign pinFall = pinPrev_q & ~pinActive;
    // ****************************************
    // per-rail dependency and slave logic
    // ****************************************
    genvar r;
    generate
        for (r = 0; r < `RSD_RAILS; r = r + 1) begin : gRail
            wire [3:0] selfMask;
            wire [3:0] onRail;
            wire [3:0] stayRail;
            wire onOk;
            wire gate;
            wire stayLoss;
            wire [`RSD_RAILS-1:0] killVec;
            assign selfMask = ~(4'h1 << r);
            assign onRail = onRailMask[4*r+3:4*r] & selfMask;
            assign stayRail = stayRailMask[4*r+3:4*r] & selfMask;
            assign onOk = ((onRail & ~pgood_q) == 4'h0) &&
                ((onPinMask[4*r+3:4*r] & ~pinActive) == 4'h0);
            assign gate = !onDepEn[r] || onOk;
            // only read in ON state, so turn-on masks stop mattering
            assign stayLoss = |(stayRail & railFall) ||
                |(stayPinMask[4*r+3:4*r] & pinFall);
            genvar m;
            for (m = 0; m < `RSD_RAILS; m = m + 1) begin : gMaster
                wire [1:0] c;
                // slave choice is stored with the master's byte
                assign c = (m == r) ? `RSD_SLV_NONE :
                    slaveCfg[8*m+2*r+1:8*m+2*r];
                assign killVec[m] =
                    (c == `RSD_SLV_IMMEDIATE && masterFault[m]) ||
                    (c == `RSD_SLV_AFTER_RETRY &&
                    masterRetryDone[m]);
            end
            rsd_rail_ctrl uCtrl (
                .clk(clk),
                .rst_n(rst_n),
                .startReq(startReq[r]),
                .startGate(gate),
                .stayLoss(stayLoss),
                .slaveKill(|killVec),
                .softMode(softMode[r]),
                .softDelay(softDelay[`RSD_DLY_W*r+`RSD_DLY_W-1:
                    `RSD_DLY_W*r]),
                .pwStart(pwStart[`RSD_PW_W*r+`RSD_PW_W-1:`RSD_PW_W*r]),
                .pwMin(pwMin[`RSD_PW_W*r+`RSD_PW_W-1:`RSD_PW_W*r]),
                .railOn_q(railOn[r]),
                .driveEn_q(driveEn[r]),
                .pulseWidth_q(pulseWidth[`RSD_PW_W*r+`RSD_PW_W-1:
                    `RSD_PW_W*r])
            );
        end
    endgenerate
    // ****************************************
    // sequencing output pins
    // ****************************************
    // overall power-good taken from raw thresholds for a faster answer
    wire allPg;
    assign allPg = &(pgOn & ~pgOff);
    // outputs only; open-drain gating is the pad's concern
    assign pinOutEn = ~pinIsInput;
    integer p;
    reg [3:0] evt;
    reg [3:0] sel;
    always @* begin
        evt = 4'h0;
        sel = 4'h0;
        pinOut = {`RSD_PINS{1'b0}};
        for (p = 0; p < `RSD_PINS; p = p + 1) begin
            evt = pinSeqCfg[8*p+`RSD_EVT_HI -: 4];
            sel = pinSeqCfg[8*p+`RSD_SEL_HI -: 4];
            case (evt)
                `RSD_EVT_REGULATING: begin
                    pinOut[p] = (sel != 4'h0) &&
                        ((sel & ~pgood_q) == 4'h0);
                end
                `RSD_EVT_POWER_GOOD: begin
                    pinOut[p] = allPg;
                end
                `RSD_EVT_ODRAIN_INIT: begin
                    pinOut[p] = hwInitDone;
                end
                `RSD_EVT_OC_WARN: begin
                    pinOut[p] = |(sel & ocWarn);
                end
                default: begin
                    pinOut[p] = 1'b0;
                end
            endcase
            pinOut[p] = pinOut[p] & ~pinIsInput[p];
        end
    end
endmodule // rsd_rail_seq
